// file: logic/nic_cmd_pkg.sv
// Shared constants, field layout and state types of the command register block
package nic_cmd_pkg;

  // ****************************************************************
  // Register indices on the four-bit register port
  // ****************************************************************
  localparam logic [3:0] CMD_INDEX = 4'h0;   // Command register, every page
  localparam logic [3:0] ISR_INDEX = 4'h7;   // Interrupt cause register, page 0

  // ****************************************************************
  // Register pages
  // ****************************************************************
  localparam logic [1:0] PAGE0     = 2'h0;
  localparam logic [1:0] PAGE1     = 2'h1;
  localparam logic [1:0] PAGE2     = 2'h2;
  localparam logic [1:0] PAGE_RSVD = 2'h3;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int OFFLINE_POS = 0;
  localparam int GO_POS      = 1;
  localparam int SEND_POS    = 2;
  localparam int RCMD_LSB    = 3;
  localparam int RCMD_MSB    = 5;
  localparam int BANK_LSB    = 6;
  localparam int ISR_RST_POS = 7;

  // ****************************************************************
  // Remote command codes
  // ****************************************************************
  localparam logic [2:0] RCMD_NONE  = 3'h0;  // Not allowed, ignored
  localparam logic [2:0] RCMD_READ  = 3'h1;
  localparam logic [2:0] RCMD_WRITE = 3'h2;
  localparam logic [2:0] RCMD_SEND  = 3'h3;
  localparam logic [2:0] RCMD_ABORT = 3'h4;  // Top bit set: abort or complete

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CMD_RESET     = 8'h21;  // Offline, not running, DMA idle
  localparam logic       ISR_RST_RESET = 1'b1;   // Device starts in reset state

  // Command byte layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] bankSelect;  // Register page
    logic [2:0] remoteCmd;   // Remote command field
    logic       sendFrame;   // Send-frame bit
    logic       goBit;       // Go bit
    logic       offlineBit;  // Offline bit
  } cmd_s;

  // Controller run state
  typedef enum logic [1:0] {CTL_OFFLINE, CTL_RUNNING, CTL_STOPPING} ctl_e;

  // Remote DMA channel mode
  typedef enum logic [1:0] {DMA_IDLE, DMA_READ, DMA_WRITE, DMA_SEND} dma_e;

endpackage

// file: logic/sticky_flag.sv
// Status flag that hardware sets and another party clears, set winning
`timescale 1ns/1ns
`default_nettype none
module sticky_flag #(
  parameter logic RESET_VALUE = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic setFlag,
  input  wire logic clearFlag,
  // State
  output var  logic flag
);

  // ****************************************************************
  // Flag storage
  // ****************************************************************

  // Set has priority so an event in the clearing cycle is kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= RESET_VALUE;
    end else if (setFlag) begin
      flag <= 1'b1;
    end else if (clearFlag) begin
      flag <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: logic/nic_command_register.sv
// Command register of the network controller: run control, send, remote DMA, page
//
// Functional notes
// - Offline bit stops reception and transmission
// - Frame in progress finishes before reset
// - Clear offline and set go to resume
// - Reset taking effect shown by status flag
// - Power-up: offline reads one, go zero
// - Stop while running keeps both bits set
// - Go activates after power-up or reset
// - Send bit starts frame, cleared on end
// - Writing zero to send bit does nothing
// - Reissued command without reload completes
// - Page, abort, offline bits always accepted
// - Top remote bit aborts any DMA
// - Abort leaves remote address where stopped
// - Port request held until acknowledge
// - Page bits select page 0, 1, 2
// - Eight-bit registers, sixteen per page
// - Reset flag sets on stop, clears on go
`timescale 1ns/1ns
`default_nettype none
module nic_command_register (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Register port
  input  wire logic [3:0]        regIndex,
  input  wire logic              regRead,
  input  wire logic              regWrite,
  input  wire logic [7:0]        writeData,
  output var  logic [7:0]        readData,
  // Controller activity
  input  wire logic              rxBusy,
  input  wire logic              txBusy,
  input  wire logic              fatalError,
  output var  logic              netEnable,
  output var  logic              resetStatus,
  // Transmit engine
  input  wire logic              txDone,
  input  wire logic              txAborted,
  output var  logic              txStart,
  // Remote DMA channel
  input  wire logic              remoteCountLoaded,
  input  wire logic              remoteCountZero,
  input  wire logic              dmaWordReady,
  input  wire logic              readAcknowledge,
  input  wire logic              writeAcknowledge,
  output var  nic_cmd_pkg::dma_e dmaMode,
  output var  logic              dmaStart,
  output var  logic              dmaAbort,
  output var  logic              dmaComplete,
  output var  logic              portRequest,
  // Page selection
  output var  logic [1:0]        bankSelect
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rstPipe_r;  // Two-stage release of the reset
  logic       rstSync_n;  // Synchronised reset used everywhere else

  // Constant input, async assert, clocked release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe_r <= 2'h0;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe_r[1];

  // ****************************************************************
  // Decode
  // ****************************************************************
  nic_cmd_pkg::cmd_s wcmd;         // Written byte seen as fields
  logic              cmdWrite;     // Write to the command register
  logic              isrSelect;    // Interrupt cause register addressed
  logic              stopReq;      // Offline request or error
  logic              startReq;     // Go with offline cleared
  logic              enterOffline; // Reset state taking effect
  logic              sendSet;      // New frame accepted
  logic              sendClr;      // Frame finished or aborted
  logic              abortReq;     // Top remote bit written
  logic              newCmd;       // Valid remote command written
  logic              quickDone;    // Reissue without reloaded count
  logic              dmaDone;      // Remote count reached zero
  nic_cmd_pkg::dma_e cmdMode;      // Mode of the written code
  logic [2:0]        remoteCmd_r;  // Remote command field
  logic              countLoaded_r; // Remote count rewritten since last command

  assign wcmd      = nic_cmd_pkg::cmd_s'(writeData);
  assign cmdWrite  = regWrite && (regIndex == nic_cmd_pkg::CMD_INDEX);
  assign isrSelect = (regIndex == nic_cmd_pkg::ISR_INDEX) &&
                     (bankSelect == nic_cmd_pkg::PAGE0);
  assign stopReq   = (cmdWrite && wcmd.offlineBit) || fatalError;
  assign startReq  = cmdWrite && wcmd.goBit && !wcmd.offlineBit;
  assign sendClr   = txDone || txAborted;
  assign abortReq  = cmdWrite && wcmd.remoteCmd[2];
  assign newCmd    = cmdWrite && !wcmd.remoteCmd[2] &&
                     (wcmd.remoteCmd != nic_cmd_pkg::RCMD_NONE);
  assign quickDone = newCmd && (dmaMode != nic_cmd_pkg::DMA_IDLE) &&
                     (wcmd.remoteCmd == remoteCmd_r) && !countLoaded_r;
  assign dmaDone   = (dmaMode != nic_cmd_pkg::DMA_IDLE) && remoteCountZero;

  // Remote code to channel mode
  assign cmdMode = (wcmd.remoteCmd == nic_cmd_pkg::RCMD_READ)  ? nic_cmd_pkg::DMA_READ  :
                   (wcmd.remoteCmd == nic_cmd_pkg::RCMD_WRITE) ? nic_cmd_pkg::DMA_WRITE :
                   (wcmd.remoteCmd == nic_cmd_pkg::RCMD_SEND)  ? nic_cmd_pkg::DMA_SEND  :
                   nic_cmd_pkg::DMA_IDLE;

  // ****************************************************************
  // Controller run state
  // ****************************************************************
  nic_cmd_pkg::ctl_e ctl_r;    // Current run state
  nic_cmd_pkg::ctl_e ctl_nxt;  // Next run state

  // Stop beats start; stopping waits for traffic to drain
  always_comb begin
    ctl_nxt = ctl_r;
    case (ctl_r)
      nic_cmd_pkg::CTL_OFFLINE: begin
        if (startReq && !fatalError) begin
          ctl_nxt = nic_cmd_pkg::CTL_RUNNING;
        end
      end
      nic_cmd_pkg::CTL_RUNNING: begin
        if (stopReq) begin
          ctl_nxt = nic_cmd_pkg::CTL_STOPPING;
        end
      end
      default: begin
        if (startReq && !fatalError) begin
          ctl_nxt = nic_cmd_pkg::CTL_RUNNING;
        end else if (!rxBusy && !txBusy) begin
          ctl_nxt = nic_cmd_pkg::CTL_OFFLINE;
        end
      end
    endcase
  end
  assign enterOffline = (ctl_r == nic_cmd_pkg::CTL_STOPPING) &&
                        (ctl_nxt == nic_cmd_pkg::CTL_OFFLINE);

  // Run state and network enable
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ctl_r     <= nic_cmd_pkg::CTL_OFFLINE;
      netEnable <= 1'b0;
    end else begin
      ctl_r     <= ctl_nxt;
      netEnable <= (ctl_nxt == nic_cmd_pkg::CTL_RUNNING);
    end
  end

  // ****************************************************************
  // Command fields
  // ****************************************************************
  logic       offline_r;      // Offline bit
  logic       go_r;           // Go bit
  logic       send_r;         // Send-frame bit
  logic       go_nxt;         // Next go bit

  // Go holds through an offline write unless already offline, where it clears; else follows the write
  assign go_nxt  = wcmd.offlineBit ? (go_r && (ctl_r != nic_cmd_pkg::CTL_OFFLINE))
                                   : wcmd.goBit;
  assign sendSet = cmdWrite && wcmd.sendFrame && !send_r && !stopReq &&
                   ((ctl_r == nic_cmd_pkg::CTL_RUNNING) || startReq);

  // Run bits
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      offline_r <= nic_cmd_pkg::CMD_RESET[nic_cmd_pkg::OFFLINE_POS];
      go_r      <= nic_cmd_pkg::CMD_RESET[nic_cmd_pkg::GO_POS];
    end else if (cmdWrite) begin
      offline_r <= wcmd.offlineBit;
      go_r      <= go_nxt;
    end else if (fatalError) begin
      offline_r <= 1'b1;
    end
  end

  // Page bits are taken on every command write
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      bankSelect <= nic_cmd_pkg::CMD_RESET[7:nic_cmd_pkg::BANK_LSB];
    end else if (cmdWrite) begin
      bankSelect <= wcmd.bankSelect;
    end
  end

  // Send bit: zero written has no effect, cleared by the engine
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      send_r  <= nic_cmd_pkg::CMD_RESET[nic_cmd_pkg::SEND_POS];
      txStart <= 1'b0;
    end else begin
      send_r  <= sendSet ? 1'b1 : (sendClr ? 1'b0 : send_r);
      txStart <= sendSet;
    end
  end

  // ****************************************************************
  // Remote DMA channel
  // ****************************************************************

  // Channel mode: abort first, then reissue, new command, completion
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      dmaMode     <= nic_cmd_pkg::DMA_IDLE;
      remoteCmd_r <= nic_cmd_pkg::CMD_RESET[nic_cmd_pkg::RCMD_MSB:nic_cmd_pkg::RCMD_LSB];
    end else if (abortReq) begin
      dmaMode     <= nic_cmd_pkg::DMA_IDLE;
      remoteCmd_r <= wcmd.remoteCmd;
    end else if (quickDone || (dmaDone && !newCmd)) begin
      dmaMode     <= nic_cmd_pkg::DMA_IDLE;
      remoteCmd_r <= nic_cmd_pkg::RCMD_ABORT;
    end else if (newCmd) begin
      dmaMode     <= cmdMode;
      remoteCmd_r <= wcmd.remoteCmd;
    end
  end

  // Event pulses; an abort only stops the channel, the datapath keeps its address
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      dmaStart    <= 1'b0;
      dmaAbort    <= 1'b0;
      dmaComplete <= 1'b0;
    end else begin
      dmaStart    <= newCmd && !abortReq && !quickDone;
      dmaAbort    <= abortReq && (dmaMode != nic_cmd_pkg::DMA_IDLE);
      dmaComplete <= !abortReq && (quickDone || (dmaDone && !newCmd));
    end
  end

  // Count reload tracker
  sticky_flag #(
    .RESET_VALUE (1'b0)
  ) u_countLoaded (
    .clk       (clk),
    .rst_n     (rstSync_n),
    .setFlag   (remoteCountLoaded),
    .clearFlag (newCmd),
    .flag      (countLoaded_r)
  );

  // Port request survives an abort until acknowledged
  sticky_flag #(
    .RESET_VALUE (1'b0)
  ) u_portRequest (
    .clk       (clk),
    .rst_n     (rstSync_n),
    .setFlag   (dmaWordReady && (dmaMode != nic_cmd_pkg::DMA_IDLE)),
    .clearFlag (readAcknowledge || writeAcknowledge),
    .flag      (portRequest)
  );

  // Reset status flag
  sticky_flag #(
    .RESET_VALUE (nic_cmd_pkg::ISR_RST_RESET)
  ) u_resetStatus (
    .clk       (clk),
    .rst_n     (rstSync_n),
    .setFlag   (enterOffline),
    .clearFlag (startReq),
    .flag      (resetStatus)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [7:0] readMux;  // Selected read value

  assign readMux = (regIndex == nic_cmd_pkg::CMD_INDEX) ?
                     {bankSelect, remoteCmd_r, send_r, go_r, offline_r} :
                   isrSelect ? {resetStatus, 7'h00} : 8'h00;

  // Read data is registered and held between reads
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      readData <= 8'h00;
    end else if (regRead) begin
      readData <= readMux;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_offlineQuiet;
    @(posedge clk) disable iff (!rstSync_n)
    (ctl_r != nic_cmd_pkg::CTL_RUNNING) |-> !netEnable;
  endproperty
  a_offlineQuiet: assert property (p_offlineQuiet) else $error("net enabled off line");

  property p_drainFirst;
    @(posedge clk) disable iff (!rstSync_n)
    (ctl_r == nic_cmd_pkg::CTL_STOPPING) && (rxBusy || txBusy) && !startReq
      |=> (ctl_r == nic_cmd_pkg::CTL_STOPPING) && !resetStatus;
  endproperty
  a_drainFirst: assert property (p_drainFirst) else $error("reset before drain");

  property p_resume;
    @(posedge clk) disable iff (!rstSync_n)
    startReq && !fatalError |=> netEnable && go_r && !offline_r && !resetStatus;
  endproperty
  a_resume: assert property (p_resume) else $error("go did not resume");

  property p_resetFlag;
    @(posedge clk) disable iff (!rstSync_n)
    enterOffline |=> resetStatus && (ctl_r == nic_cmd_pkg::CTL_OFFLINE);
  endproperty
  a_resetFlag: assert property (p_resetFlag) else $error("reset flag missing");

  property p_powerUp;
    @(posedge clk) disable iff (!reset_n)
    $rose(rstSync_n) |-> offline_r && !go_r && resetStatus;
  endproperty
  a_powerUp: assert property (p_powerUp) else $error("bad power-up bits");

  property p_stopKeepsGo;
    @(posedge clk) disable iff (!rstSync_n)
    cmdWrite && wcmd.offlineBit && (ctl_r == nic_cmd_pkg::CTL_RUNNING)
      |=> offline_r && go_r;
  endproperty
  a_stopKeepsGo: assert property (p_stopKeepsGo) else $error("stop lost go bit");

  property p_sendStart;
    @(posedge clk) disable iff (!rstSync_n)
    sendSet |=> txStart && send_r ##1 !txStart;
  endproperty
  a_sendStart: assert property (p_sendStart) else $error("send not started");

  property p_sendHold;
    @(posedge clk) disable iff (!rstSync_n)
    send_r && !sendClr |=> send_r;
  endproperty
  a_sendHold: assert property (p_sendHold) else $error("send bit dropped");

  property p_quickDone;
    @(posedge clk) disable iff (!rstSync_n)
    quickDone && !abortReq |=> dmaComplete && (dmaMode == nic_cmd_pkg::DMA_IDLE);
  endproperty
  a_quickDone: assert property (p_quickDone) else $error("reissue did not finish");

  property p_abort;
    @(posedge clk) disable iff (!rstSync_n)
    abortReq |=> (dmaMode == nic_cmd_pkg::DMA_IDLE) && !dmaStart;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");

  property p_portHold;
    @(posedge clk) disable iff (!rstSync_n)
    portRequest && !readAcknowledge && !writeAcknowledge |=> portRequest;
  endproperty
  a_portHold: assert property (p_portHold) else $error("port request dropped");

  property p_page;
    @(posedge clk) disable iff (!rstSync_n)
    cmdWrite |=> bankSelect == $past(writeData[7:6]);
  endproperty
  a_page: assert property (p_page) else $error("page not taken");

endmodule
`default_nettype wire

// file: verif/nic_host_model.sv
// Host processor model driving the parallel register port
`timescale 1ns/1ns
`default_nettype none
module nic_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  input  wire logic [7:0] readData,
  output var  logic [3:0] regIndex,
  output var  logic       regRead,
  output var  logic       regWrite,
  output var  logic [7:0] writeData
);
  // Idle bus at time zero
  initial begin
    regIndex = 4'h0;
    regRead = 1'b0;
    regWrite = 1'b0;
    writeData = 8'h00;
  end

  // One write cycle, lines changed just after the edge
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    @(posedge clk);
    #1;
    regIndex = idx;
    writeData = d;
    regWrite = 1'b1;
    @(posedge clk);
    #1;
    regWrite = 1'b0;
    // Released data lines show the inverted data, not the old value
    writeData = ~d;
  endtask

  // One read cycle; data is taken once the read edge has landed
  task automatic rd(input logic [3:0] idx, output logic [7:0] d);
    @(posedge clk);
    #1;
    regIndex = idx;
    regRead = 1'b1;
    @(posedge clk);
    #1;
    regRead = 1'b0;
    d = readData;
  endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench of the command register block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic              clk;
  logic              reset_n;
  logic [9:0]        inp;  // rx,tx,err,done,abt,load,zero,word,read_acknowledge,write_acknowledge
  logic [3:0]        regIndex;
  logic              regRead;
  logic              regWrite;
  logic [7:0]        writeData;
  logic [7:0]        readData;
  logic [7:0]        rv;
  logic              netEnable, resetStatus, txStart;
  logic              dmaStart, dmaAbort, dmaComplete, portRequest;
  logic [1:0]        bankSelect;
  nic_cmd_pkg::dma_e dmaMode;
  logic [31:0]       seed;
  int                fails, cmpCount;

  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  nic_host_model host_i (.clk(clk), .readData(readData), .regIndex(regIndex),
    .regRead(regRead), .regWrite(regWrite), .writeData(writeData));

  nic_command_register nic_command_register_i (.clk(clk), .reset_n(reset_n),
    .regIndex(regIndex), .regRead(regRead), .regWrite(regWrite),
    .writeData(writeData), .readData(readData), .rxBusy(inp[0]), .txBusy(inp[1]),
    .fatalError(inp[2]), .netEnable(netEnable), .resetStatus(resetStatus),
    .txDone(inp[3]), .txAborted(inp[4]), .txStart(txStart),
    .remoteCountLoaded(inp[5]), .remoteCountZero(inp[6]), .dmaWordReady(inp[7]),
    .readAcknowledge(inp[8]), .writeAcknowledge(inp[9]), .dmaMode(dmaMode),
    .dmaStart(dmaStart), .dmaAbort(dmaAbort), .dmaComplete(dmaComplete),
    .portRequest(portRequest), .bankSelect(bankSelect));

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Register read compared with the bench model
  task automatic rdChk(input logic [3:0] idx, input logic [7:0] exp);
    host_i.rd(idx, rv);
    chk(rv, exp);
  endtask

  // Next value of the stimulus shift register
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // One-cycle pulse on an activity input
  task automatic pulse(input int k);
    @(posedge clk);
    #1 inp[k] = 1'b1;
    @(posedge clk);
    #1 inp[k] = 1'b0;
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    reset_n = 1'b0;
    inp = 10'h000;
    fails = 0;
    cmpCount = 0;
    seed = 32'hdb71;
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge clk);
    rdChk(4'h0, nic_cmd_pkg::CMD_RESET);
    rdChk(4'h7, 8'h80);
    // Start from reset state
    host_i.wr(4'h0, 8'h22);
    chk({resetStatus, netEnable}, 8'h01);
    rdChk(4'h7, 8'h00);
    // Frame send, completed by the engine
    host_i.wr(4'h0, 8'h26);
    chk({7'h0, txStart}, 8'h01);
    pulse(3);
    rdChk(4'h0, 8'h22);
    // Remote codes each started, serviced and aborted, never overlapped
    for (int c = 1; c < 4; c++) begin
      if (c == 2) pulse(5);
      host_i.wr(4'h0, {2'b00, c[2:0], 3'b010});
      chk({5'h0, dmaMode, dmaStart}, {5'h0, c[1:0], 1'b1});
      pulse(7);
      host_i.wr(4'h0, 8'h22);
      chk({4'h0, dmaMode, dmaAbort, portRequest}, 8'h03);
      pulse(c == 2 ? 9 : 8);
      chk({7'h0, portRequest}, 8'h00);
    end
    // Send while a read is running, field reissued without reload
    host_i.wr(4'h0, 8'h0a);
    host_i.wr(4'h0, 8'h0e);
    chk({6'h0, txStart, dmaComplete}, 8'h03);
    host_i.wr(4'h0, 8'h22);
    rdChk(4'h0, 8'h26);
    pulse(4);
    rdChk(4'h0, 8'h22);
    // Write run ended by the count reaching zero
    pulse(5);
    host_i.wr(4'h0, 8'h12);
    pulse(6);
    chk({5'h0, dmaMode, dmaComplete}, 8'h01);
    pulse(5);
    // Stop while a frame is busy
    inp[1] = 1'b1;
    host_i.wr(4'h0, 8'h21);
    repeat (3) @(posedge clk);
    chk({resetStatus, netEnable}, 8'h00);
    rdChk(4'h0, 8'h23);
    #1 inp[1] = 1'b0;
    for (int i = 0; i < 8 && resetStatus !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    #1 chk({7'h0, resetStatus}, 8'h01);
    // Error stop, then go again
    host_i.wr(4'h0, 8'h22);
    pulse(2);
    chk({7'h0, netEnable}, 8'h00);
    host_i.wr(4'h0, 8'h22);
    chk({7'h0, netEnable}, 8'h01);
    // Every page, command byte read back on each
    for (int p = 0; p < 4; p++) begin
      host_i.wr(4'h0, {p[1:0], 6'h22});
      chk({6'h0, bankSelect}, {6'h0, p[1:0]});
      rdChk(4'h0, {p[1:0], 6'h22});
    end
    host_i.wr(4'h0, 8'h22);
    // Random writes to other indices leave the command byte alone
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      host_i.wr((seed[3:0] == 4'h0 || seed[3:0] == 4'h7) ? 4'h8 : seed[3:0], seed[11:4]);
      rdChk(4'h0, 8'h22);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
